// file: design/cwd_config_decode.sv
// Configuration fuse word store, identification word and option decode.
// Assumes a programmer access port already decoded from the serial link,
// and program/data memory arrays held outside this block.
`timescale 1ns/1ps
`default_nettype none

module cwd_config_decode #(
	parameter int                                 PROG_WORDS = 8192,
	parameter logic [cwd_pkg::PART_CODE_W-1:0]    PART_CODE  = 9'h0a5, // Arbitrary value
	parameter logic [cwd_pkg::REV_CODE_W-1:0]     REV_CODE   = 5'h01,  // Arbitrary value
	parameter logic [13:0]                        FUSE_INIT  = cwd_pkg::CFG_ERASED
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// Programmer access
	input  wire logic [13:0]       prog_addr,
	input  wire logic              prog_data_space,
	input  wire logic              prog_rd,
	input  wire logic              prog_wr,
	input  wire logic [13:0]       prog_wdata,
	input  wire logic              prog_bulk_erase,
	output var  logic [13:0]       prog_rdata,
	output var  logic              prog_rvalid,
	output var  logic              prog_refused,
	// Memory array side
	input  wire logic [13:0]       mem_rdata,
	output var  logic              mem_wr_en,
	output var  logic              mem_wr_data_space,
	output var  logic [12:0]       mem_wr_addr,
	output var  logic [13:0]       mem_wr_data,
	// Running program self-write
	input  wire logic              cpu_pm_wr,
	input  wire logic [12:0]       cpu_pm_addr,
	output var  logic              cpu_pm_wr_grant,
	output var  logic              cpu_pm_wr_deny,
	// Pins
	input  wire logic              prog_select_pin,
	input  wire logic              master_clear_pin_hv,
	output var  logic              low_volt_entry_input,
	output var  logic              prog_select_gpio_in,
	output var  logic              prog_mode_entry,
	// Decoded options
	output var  cwd_pkg::cwd_opts_s opts
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	generate
		if (PROG_WORDS != 4096 && PROG_WORDS != 8192) begin : g_bad_size
			$error("PROG_WORDS must be 4096 or 8192");
		end
	endgenerate

	localparam logic [13:0] ID_WORD = {PART_CODE, REV_CODE};

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic in_prot(input logic [12:0] a, input logic [12:0] b,
		input logic n);
		in_prot = !n && (a >= b);
	endfunction

	// ****************************************************************
	// Fuse word and protection region
	// ****************************************************************
	logic [13:0] fuse;
	logic [13:0] next_fuse;
	logic [1:0]  cp_merged;
	logic [12:0] prot_base;
	logic        prot_none;

	// Both copies count; a zero in either copy protects, so a half-programmed
	// pair can never weaken protection.
	assign cp_merged = {fuse[cwd_pkg::BIT_CP_HI_A] & fuse[cwd_pkg::BIT_CP_HI_B],
		fuse[cwd_pkg::BIT_CP_LO_A] & fuse[cwd_pkg::BIT_CP_LO_B]};

	cwd_prot_limit #(
		.PROG_WORDS (PROG_WORDS)
	) u_prot_limit (
		.field (cp_merged),
		.base  (prot_base),
		.none  (prot_none)
	);

	logic        is_cfg;
	logic        is_id;
	logic        is_user;
	logic        pm_prot;
	logic        ee_prot;

	assign is_cfg  = !prog_data_space && (prog_addr == cwd_pkg::CFG_ADDR);
	assign is_id   = !prog_data_space && (prog_addr == cwd_pkg::ID_ADDR);
	assign is_user = prog_data_space || (prog_addr < cwd_pkg::CFG_SPACE_BASE);
	assign pm_prot = in_prot(prog_addr[12:0], prot_base, prot_none);
	assign ee_prot = !fuse[cwd_pkg::BIT_CPD];

	always_comb begin
		next_fuse = fuse;
		// Bulk erase returns every fuse to one; it outranks a same-cycle write
		if (prog_bulk_erase) begin
			next_fuse = cwd_pkg::CFG_ERASED;
		end else if (prog_wr && is_cfg) begin
			// Fuse word stays writable even on a protected part
			next_fuse = prog_wdata | cwd_pkg::UNIMPL_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fuse <= FUSE_INIT;
		end else begin
			fuse <= next_fuse;
		end
	end

	// ****************************************************************
	// Programmer read and write path
	// ****************************************************************
	logic [13:0] next_prog_rdata;
	logic        next_prog_rvalid;
	logic        next_prog_refused;
	logic        next_mem_wr_en;
	logic        next_mem_wr_data_space;
	logic [12:0] next_mem_wr_addr;
	logic [13:0] next_mem_wr_data;

	always_comb begin
		next_prog_rdata        = '0;
		next_prog_rvalid       = prog_rd;
		next_prog_refused      = 1'b0;
		next_mem_wr_en         = 1'b0;
		next_mem_wr_data_space = prog_data_space;
		next_mem_wr_addr       = prog_addr[12:0];
		next_mem_wr_data       = prog_wdata;
		if (prog_rd) begin
			if (is_id) begin
				next_prog_rdata = ID_WORD;
			end else if (is_cfg) begin
				next_prog_rdata = fuse;
			end else if (prog_data_space) begin
				// Only the low byte of a data location is real
				next_prog_rdata = ee_prot ? 14'h0000 :
					{6'h00, mem_rdata[7:0] & cwd_pkg::EE_DATA_MASK};
			end else if (is_user) begin
				next_prog_rdata = pm_prot ? 14'h0000 : mem_rdata;
			end else begin
				next_prog_rdata = mem_rdata;
			end
		end
		if (prog_wr && !prog_bulk_erase) begin
			if (is_id) begin
				next_prog_refused = 1'b1;
			end else if (prog_data_space ? ee_prot : (is_user && pm_prot)) begin
				next_prog_refused = 1'b1;
			end else if (!is_cfg) begin
				next_mem_wr_en = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prog_rdata        <= '0;
			prog_rvalid       <= 1'b0;
			prog_refused      <= 1'b0;
			mem_wr_en         <= 1'b0;
			mem_wr_data_space <= 1'b0;
			mem_wr_addr       <= '0;
			mem_wr_data       <= '0;
		end else begin
			prog_rdata        <= next_prog_rdata;
			prog_rvalid       <= next_prog_rvalid;
			prog_refused      <= next_prog_refused;
			mem_wr_en         <= next_mem_wr_en;
			mem_wr_data_space <= next_mem_wr_data_space;
			mem_wr_addr       <= next_mem_wr_addr;
			mem_wr_data       <= next_mem_wr_data;
		end
	end

	// ****************************************************************
	// Running program self-write gate
	// ****************************************************************
	logic next_cpu_grant;
	logic next_cpu_deny;

	always_comb begin
		next_cpu_grant = 1'b0;
		next_cpu_deny  = 1'b0;
		if (cpu_pm_wr) begin
			if (fuse[cwd_pkg::BIT_WRT] && !in_prot(cpu_pm_addr, prot_base, prot_none)) begin
				next_cpu_grant = 1'b1;
			end else begin
				next_cpu_deny = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cpu_pm_wr_grant <= 1'b0;
			cpu_pm_wr_deny  <= 1'b0;
		end else begin
			cpu_pm_wr_grant <= next_cpu_grant;
			cpu_pm_wr_deny  <= next_cpu_deny;
		end
	end

	// ****************************************************************
	// Pin function and programming entry
	// ****************************************************************
	logic next_lv_entry;
	logic next_gpio_in;
	logic next_entry;

	always_comb begin
		if (fuse[cwd_pkg::BIT_LVP]) begin
			next_lv_entry = prog_select_pin;
			next_gpio_in  = 1'b0;
		end else begin
			next_lv_entry = 1'b0;
			next_gpio_in  = prog_select_pin;
		end
		// High voltage on master clear always works; the pin path only with the fuse
		next_entry = master_clear_pin_hv || next_lv_entry;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			low_volt_entry_input <= 1'b0;
			prog_select_gpio_in  <= 1'b0;
			prog_mode_entry      <= 1'b0;
		end else begin
			low_volt_entry_input <= next_lv_entry;
			prog_select_gpio_in  <= next_gpio_in;
			prog_mode_entry      <= next_entry;
		end
	end

	// ****************************************************************
	// Option decode
	// ****************************************************************
	cwd_pkg::cwd_opts_s next_opts;

	always_comb begin
		next_opts.self_write_permit     = fuse[cwd_pkg::BIT_WRT];
		next_opts.data_eeprom_protect   = !fuse[cwd_pkg::BIT_CPD];
		next_opts.low_volt_prog_enable  = fuse[cwd_pkg::BIT_LVP];
		next_opts.brownout_reset_enable = fuse[cwd_pkg::BIT_BROWNOUT_RESET_ENABLE];
		// Brown-out reset needs the power-up delay, so it overrides the fuse
		next_opts.powerup_timer_on      = !fuse[cwd_pkg::BIT_POWERUP_TIMER_ENABLE_N_N]
			|| fuse[cwd_pkg::BIT_BROWNOUT_RESET_ENABLE];
		next_opts.watchdog_enable       = fuse[cwd_pkg::BIT_WATCHDOG_ENABLE];
		case (fuse[cwd_pkg::BIT_OSC_HI:cwd_pkg::BIT_OSC_LO])
			cwd_pkg::OSC_CODE_RC: begin
				next_opts.osc_mode = cwd_pkg::OSC_RC;
			end
			cwd_pkg::OSC_CODE_HS: begin
				next_opts.osc_mode = cwd_pkg::OSC_HS;
			end
			cwd_pkg::OSC_CODE_XT: begin
				next_opts.osc_mode = cwd_pkg::OSC_XT;
			end
			default: begin
				next_opts.osc_mode = cwd_pkg::OSC_OTHER;
			end
		endcase
		next_opts.prog_protect_none     = prot_none;
		next_opts.prog_protect_base     = prot_base;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			opts <= '0;
		end else begin
			opts <= next_opts;
		end
	end

endmodule

`default_nettype wire

// file: include/cwd_pkg.sv
// Constants, field layout and carrier types for the configuration word decoder.
// Assumes a 14-bit configuration space address and 14-bit words.
package cwd_pkg;

	// ****************************************************************
	// Configuration space addresses
	// ****************************************************************
	localparam logic [13:0] ID_ADDR        = 14'h2006;
	localparam logic [13:0] CFG_ADDR       = 14'h2007;
	localparam logic [13:0] CFG_SPACE_BASE = 14'h2000;

	// ****************************************************************
	// Fuse word layout and values
	// ****************************************************************
	localparam logic [13:0] CFG_ERASED     = 14'h3fff;
	localparam int          BIT_CP_HI_A    = 13;
	localparam int          BIT_CP_LO_A    = 12;
	localparam int          BIT_RESERVED_SET_ONE       = 11;
	localparam int          BIT_UNIMPL     = 10;
	localparam int          BIT_WRT        = 9;
	localparam int          BIT_CPD        = 8;
	localparam int          BIT_LVP        = 7;
	localparam int          BIT_BROWNOUT_RESET_ENABLE      = 6;
	localparam int          BIT_CP_HI_B    = 5;
	localparam int          BIT_CP_LO_B    = 4;
	localparam int          BIT_POWERUP_TIMER_ENABLE_N_N    = 3;
	localparam int          BIT_WATCHDOG_ENABLE       = 2;
	localparam int          BIT_OSC_HI     = 1;
	localparam int          BIT_OSC_LO     = 0;
	localparam logic [13:0] UNIMPL_MASK    = 14'h0400;

	// ****************************************************************
	// Field codes
	// ****************************************************************
	localparam logic [1:0]  CP_NONE        = 2'h3;
	localparam logic [1:0]  CP_TOP_BLOCK   = 2'h2;
	localparam logic [1:0]  CP_UPPER_HALF  = 2'h1;
	localparam logic [1:0]  OSC_CODE_RC    = 2'h3;
	localparam logic [1:0]  OSC_CODE_HS    = 2'h2;
	localparam logic [1:0]  OSC_CODE_XT    = 2'h1;
	localparam int          PROT_BLOCK_WORDS = 256;
	localparam logic [7:0]  EE_DATA_MASK   = 8'hff;

	// ****************************************************************
	// Identification word layout
	// ****************************************************************
	localparam int          PART_CODE_W    = 9;
	localparam int          REV_CODE_W     = 5;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		OSC_RC,
		OSC_HS,
		OSC_XT,
		OSC_OTHER
	} cwd_osc_e;

	typedef struct packed {
		logic     self_write_permit;
		logic     data_eeprom_protect;
		logic     low_volt_prog_enable;
		logic     brownout_reset_enable;
		logic     powerup_timer_on;
		logic     watchdog_enable;
		cwd_osc_e osc_mode;
		logic     prog_protect_none;
		logic [12:0] prog_protect_base;
	} cwd_opts_s;

endpackage

// file: design/cwd_prot_limit.sv
// Turns the merged program protection field into the lowest protected address.
// Assumes the caller merges both copies of the field before passing it in.
`timescale 1ns/1ps
`default_nettype none

module cwd_prot_limit #(
	parameter int PROG_WORDS = 8192
) (
	// Field in
	input  wire logic [1:0]  field,
	// Protected region out
	output var  logic [12:0] base,
	output var  logic        none
);

	localparam int PA_W = 13;

	// The base must fit the 13-bit word address and hold a whole top block
	generate
		if (PROG_WORDS < cwd_pkg::PROT_BLOCK_WORDS || PROG_WORDS > (1 << PA_W)) begin : g_bad_size
			$error("PROG_WORDS does not fit the protection decode");
		end
	endgenerate

	// ****************************************************************
	// Region decode
	// ****************************************************************
	always_comb begin
		none = 1'b0;
		base = '0;
		case (field)
			cwd_pkg::CP_NONE: begin
				none = 1'b1;
			end
			cwd_pkg::CP_TOP_BLOCK: begin
				base = PA_W'(PROG_WORDS - cwd_pkg::PROT_BLOCK_WORDS);
			end
			cwd_pkg::CP_UPPER_HALF: begin
				base = PA_W'(PROG_WORDS / 2);
			end
			default: begin
				base = '0;
			end
		endcase
	end

endmodule

`default_nettype wire

// file: tb/cwd_config_decode_assertions.sv
// Port checker for the configuration word decoder.
// Assumes it is bound to every cwd_config_decode instance.
`timescale 1ns/1ps
`default_nettype none
module cwd_config_decode_assertions #(
	parameter logic [cwd_pkg::PART_CODE_W-1:0] PART_CODE = 9'h0a5,
	parameter logic [cwd_pkg::REV_CODE_W-1:0]  REV_CODE  = 5'h01
) (
	// Clock and reset
	input wire logic               clk,
	input wire logic               reset,
	// Programmer port
	input wire logic [13:0]        prog_addr,
	input wire logic               prog_data_space,
	input wire logic               prog_rd,
	input wire logic               prog_wr,
	input wire logic [13:0]        prog_wdata,
	input wire logic               prog_bulk_erase,
	input wire logic [13:0]        prog_rdata,
	input wire logic               prog_rvalid,
	input wire logic               prog_refused,
	input wire logic               mem_wr_en,
	// Self-write and pins
	input wire logic               cpu_pm_wr,
	input wire logic               cpu_pm_wr_grant,
	input wire logic               cpu_pm_wr_deny,
	input wire logic               prog_select_pin,
	input wire logic               low_volt_entry_input,
	input wire logic               prog_select_gpio_in,
	input wire cwd_pkg::cwd_opts_s opts
);
	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic id_acc, cfg_wr, cfg_set;
	assign id_acc = !prog_data_space && prog_addr == cwd_pkg::ID_ADDR;
	assign cfg_wr = prog_wr && !prog_data_space && prog_addr == cwd_pkg::CFG_ADDR;
	assign cfg_set = cfg_wr && !prog_bulk_erase;
	a_rd_answer: assert property (prog_rd |=> prog_rvalid) else $error("read not answered");
	a_id_value: assert property (prog_rd && id_acc |=> prog_rdata == {PART_CODE, REV_CODE})
		else $error("bad id word");
	a_id_refuse: assert property (prog_wr && !prog_bulk_erase && id_acc |=> prog_refused && !mem_wr_en)
		else $error("id write not refused");
	a_fuse_accept: assert property (cfg_wr |=> !prog_refused && !mem_wr_en)
		else $error("fuse write mishandled");
	// A second fuse write or an erase in the next cycle would move the options again
	a_wdt_follow: assert property (cfg_set ##1 !(cfg_wr || prog_bulk_erase) |=>
		opts.watchdog_enable == $past(prog_wdata[2], 2)) else $error("watchdog decode");
	// Brown-out must win over the timer bit, so both bits are looked at
	a_pwrt_force: assert property (cfg_set ##1 !(cfg_wr || prog_bulk_erase) |=>
		opts.powerup_timer_on == (!$past(prog_wdata[3], 2) || $past(prog_wdata[6], 2)))
		else $error("timer decode");
	a_cpu_answer: assert property (cpu_pm_wr |=> cpu_pm_wr_grant != cpu_pm_wr_deny)
		else $error("self write answer");
	a_grant_permit: assert property (cpu_pm_wr_grant |-> opts.self_write_permit)
		else $error("grant without permit");
	a_pin_route: assert property (!$past(reset) |->
		low_volt_entry_input == ($past(prog_select_pin) && opts.low_volt_prog_enable) &&
		prog_select_gpio_in == ($past(prog_select_pin) && !opts.low_volt_prog_enable))
		else $error("pin routing");
	c_id_read: cover property (prog_rd && id_acc);
	c_grant: cover property (cpu_pm_wr_grant);
	c_deny: cover property (cpu_pm_wr_deny);
endmodule
bind cwd_config_decode cwd_config_decode_assertions #(
	.PART_CODE(PART_CODE),
	.REV_CODE (REV_CODE)
) u_chk (.*);
`default_nettype wire

// file: tb/cwd_mem_model.sv
// Program and data array model feeding raw words to the decoder.
// Assumes a flow-through array read straight from the address.
`timescale 1ns/1ps
`default_nettype none
module cwd_mem_model (
	// Array access
	input  wire logic [13:0] addr,
	output var  logic [13:0] rdata
);
	// Address-derived pattern, so a zeroed or stale word never passes for data
	assign rdata = {addr[6:0], ~addr[6:0]};
endmodule
`default_nettype wire

// file: tb/cwd_config_decode_tb.sv
// Self-checking bench for the configuration word decoder.
// Assumes the array model answers reads combinationally.
`timescale 1ns/1ps
`default_nettype none
module cwd_config_decode_tb;
	localparam logic [8:0] PC = 9'h15a; // Arbitrary value
	localparam logic [4:0] RC = 5'h0b;  // Arbitrary value
	logic clk, reset, prog_data_space, prog_rd, prog_wr, prog_bulk_erase, cpu_pm_wr;
	logic prog_select_pin, master_clear_pin_hv, prog_rvalid, prog_refused, mem_wr_en;
	logic mem_wr_data_space, cpu_pm_wr_grant, cpu_pm_wr_deny, prog_mode_entry;
	logic low_volt_entry_input, prog_select_gpio_in, refused_4k;
	logic [13:0] prog_addr, prog_wdata, mem_rdata, prog_rdata, mem_wr_data;
	logic [12:0] cpu_pm_addr, mem_wr_addr;
	cwd_pkg::cwd_opts_s opts;
	int error_cnt = 0;
	int comparisons = 0;
	cwd_pkg::cwd_osc_e osc_tab[4] = '{cwd_pkg::OSC_OTHER, cwd_pkg::OSC_XT,
		cwd_pkg::OSC_HS, cwd_pkg::OSC_RC};
	// Fuse word, target address, refused, lowest protected word
	logic [13:0] pf[7] = '{14'h2fef, 14'h2fef, 14'h1fdf, 14'h1fdf, 14'h3fff, 14'h0fcf, 14'h3fef};
	logic [13:0] pa[7] = '{14'h1f00, 14'h1eff, 14'h1000, 14'h0fff, 14'h1fff, 14'h0000, 14'h1f00};
	logic        pr[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
	logic [13:0] pb[7] = '{14'h1f00, 14'h1f00, 14'h1000, 14'h1000, 14'h0000, 14'h0000, 14'h1f00};

	cwd_config_decode #(.PROG_WORDS(8192), .PART_CODE(PC), .REV_CODE(RC)) uut (.*);
	// Smaller part shares every input; only its refusal is looked at
	cwd_config_decode #(.PROG_WORDS(4096)) uut_4k (
		.clk                  (clk),
		.reset                (reset),
		.prog_addr            (prog_addr),
		.prog_data_space      (prog_data_space),
		.prog_rd              (prog_rd),
		.prog_wr              (prog_wr),
		.prog_wdata           (prog_wdata),
		.prog_bulk_erase      (prog_bulk_erase),
		.prog_rdata           (),
		.prog_rvalid          (),
		.prog_refused         (refused_4k),
		.mem_rdata            (mem_rdata),
		.mem_wr_en            (),
		.mem_wr_data_space    (),
		.mem_wr_addr          (),
		.mem_wr_data          (),
		.cpu_pm_wr            (cpu_pm_wr),
		.cpu_pm_addr          (cpu_pm_addr),
		.cpu_pm_wr_grant      (),
		.cpu_pm_wr_deny       (),
		.prog_select_pin      (prog_select_pin),
		.master_clear_pin_hv  (master_clear_pin_hv),
		.low_volt_entry_input (),
		.prog_select_gpio_in  (),
		.prog_mode_entry      (),
		.opts                 ()
	);
	cwd_mem_model u_mem (.addr(prog_addr), .rdata(mem_rdata));

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk_w(input logic [13:0] got, input logic [13:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task chk_b(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One request cycle; answers are looked at on the following falling edge
	task op(input logic r, w, ds, input logic [13:0] a, d);
		@(negedge clk);
		{prog_rd, prog_wr, prog_data_space, prog_addr, prog_wdata} = {r, w, ds, a, d};
		@(negedge clk);
		{prog_rd, prog_wr} = 2'b00;
	endtask
	task rd(input logic ds, input logic [13:0] a, exp);
		op(1'b1, 1'b0, ds, a, 14'h0);
		chk_b(prog_rvalid, 1'b1);
		chk_w(prog_rdata, exp);
	endtask
	task wr(input logic ds, input logic [13:0] a, d, input logic refused, wen);
		op(1'b0, 1'b1, ds, a, d);
		chk_b(prog_refused, refused);
		chk_b(mem_wr_en, wen);
		if (wen) begin
			chk_w(mem_wr_data, d);
			chk_w({1'b0, mem_wr_addr}, {1'b0, a[12:0]});
			chk_b(mem_wr_data_space, ds);
		end
	endtask
	// Extra cycle lets the decoded options catch up with the fuse
	task fuse(input logic [13:0] w);
		wr(1'b0, cwd_pkg::CFG_ADDR, w, 1'b0, 1'b0);
		@(negedge clk);
	endtask
	task cpu(input logic [12:0] a, input logic g);
		@(negedge clk);
		{cpu_pm_wr, cpu_pm_addr} = {1'b1, a};
		@(negedge clk);
		cpu_pm_wr = 1'b0;
		chk_b(cpu_pm_wr_grant, g);
		chk_b(cpu_pm_wr_deny, !g);
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		logic [13:0] w;
		{prog_rd, prog_wr, prog_data_space, prog_bulk_erase, cpu_pm_wr} = 5'h00;
		{prog_select_pin, master_clear_pin_hv, prog_addr, prog_wdata, cpu_pm_addr} = '0;
		reset = 1'b1;
		repeat (5) @(negedge clk);
		reset = 1'b0;
		rd(1'b0, cwd_pkg::CFG_ADDR, 14'h3fff);
		rd(1'b0, cwd_pkg::ID_ADDR, {PC, RC});
		wr(1'b0, cwd_pkg::ID_ADDR, 14'h0000, 1'b1, 1'b0);
		rd(1'b0, cwd_pkg::ID_ADDR, {PC, RC});
		for (int i = 0; i < 4; i++) begin
			w = 14'h3fb0 | {7'h00, i[0], 2'h0, i[1], i[0], i[1:0]};
			fuse(w);
			rd(1'b0, cwd_pkg::CFG_ADDR, w);
			chk_w({12'h000, opts.osc_mode}, {12'h000, osc_tab[i]});
			chk_b(opts.watchdog_enable, i[0]);
			chk_b(opts.brownout_reset_enable, i[0]);
			chk_b(opts.powerup_timer_on, !i[1] || i[0]);
		end
		prog_select_pin = 1'b1;
		repeat (2) @(negedge clk);
		chk_b(low_volt_entry_input, 1'b1);
		chk_b(prog_select_gpio_in, 1'b0);
		chk_b(prog_mode_entry, 1'b1);
		fuse(14'h3f7f);
		chk_b(opts.low_volt_prog_enable, 1'b0);
		chk_b(low_volt_entry_input, 1'b0);
		chk_b(prog_select_gpio_in, 1'b1);
		chk_b(prog_mode_entry, 1'b0);
		master_clear_pin_hv = 1'b1;
		@(negedge clk);
		chk_b(prog_mode_entry, 1'b1);
		fuse(14'h3eff);
		chk_b(opts.data_eeprom_protect, 1'b1);
		wr(1'b1, 14'h0010, 14'h0055, 1'b1, 1'b0);
		rd(1'b1, 14'h0010, 14'h0000);
		fuse(14'h3fff);
		chk_b(opts.data_eeprom_protect, 1'b0);
		wr(1'b1, 14'h0010, 14'h0055, 1'b0, 1'b1);
		rd(1'b1, 14'h0010, 14'h006f);
		// Top block sits lower on the smaller part
		fuse(14'h2fef);
		wr(1'b0, 14'h0f00, 14'h1234, 1'b0, 1'b1);
		chk_b(refused_4k, 1'b1);
		wr(1'b0, 14'h0eff, 14'h1234, 1'b0, 1'b1);
		chk_b(refused_4k, 1'b0);
		fuse(14'h3fff);
		wr(1'b0, 14'h0f00, 14'h1234, 1'b0, 1'b1);
		chk_b(refused_4k, 1'b0);
		for (int k = 0; k < 7; k++) begin
			fuse(pf[k]);
			chk_b(opts.prog_protect_none, k == 4);
			chk_w({1'b0, opts.prog_protect_base}, pb[k]);
			wr(1'b0, pa[k], 14'h1234, pr[k], !pr[k]);
			rd(1'b0, pa[k], pr[k] ? 14'h0000 : {pa[k][6:0], ~pa[k][6:0]});
		end
		chk_b(opts.self_write_permit, 1'b1);
		cpu(13'h1f00, 1'b0);
		cpu(13'h0100, 1'b1);
		fuse(14'h3dff);
		chk_b(opts.self_write_permit, 1'b0);
		cpu(13'h0100, 1'b0);
		@(negedge clk);
		prog_bulk_erase = 1'b1;
		@(negedge clk);
		prog_bulk_erase = 1'b0;
		rd(1'b0, cwd_pkg::CFG_ADDR, 14'h3fff);
		// Erase and fuse write taken at one edge: the erase must win
		@(negedge clk);
		{prog_wr, prog_bulk_erase, prog_addr, prog_wdata} = {1'b1, 1'b1, cwd_pkg::CFG_ADDR, 14'h0000};
		@(negedge clk);
		{prog_wr, prog_bulk_erase} = 2'b00;
		chk_b(prog_refused, 1'b0);
		chk_b(mem_wr_en, 1'b0);
		rd(1'b0, cwd_pkg::CFG_ADDR, 14'h3fff);
		end_sim;
	end

	// Whole run is about 130 cycles; this leaves ample margin
	initial begin
		#40us;
		error_cnt++;
		end_sim;
	end
endmodule
`default_nettype wire
